// [fault_mon_pkg.sv]
/*
 * Shared constants for the chip-level fault supervisor: register map,
 * field positions, reset values, serial frame layout, save status codes,
 * logic-regulator sequencer states and supervision times.
 * Assumes a single 250 MHz system clock.
 */
`default_nettype none

package fault_mon_pkg;

    // register bus
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 32;
    localparam logic [4:0]  CTRL_OFS      = 5'h00;
    localparam logic [4:0]  SPEED_OFS     = 5'h04;
    localparam logic [4:0]  STATUS_OFS    = 5'h08;
    localparam logic [4:0]  US_THR_OFS    = 5'h0c;
    localparam logic [4:0]  OS_THR_OFS    = 5'h10;

    // control register
    localparam int          CTRL_W        = 3;
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_RSC_BIT  = 1;
    localparam int          CTRL_DSR_BIT  = 2;
    localparam logic [2:0]  CTRL_RST      = 3'h0;

    // speed configuration register
    localparam int          SPD_W         = 11;
    localparam int          US_LSB        = 0;
    localparam int          OS_LSB        = 4;
    localparam int          RES_LSB       = 8;
    localparam logic [10:0] SPD_RST       = 11'h0f1;

    // status flags
    localparam int          FLAG_W        = 7;
    localparam int          ST_FF         = 0;
    localparam int          ST_POR        = 1;
    localparam int          ST_CPUV       = 2;
    localparam int          ST_LRUV       = 3;
    localparam int          ST_PPUV       = 4;
    localparam int          ST_SE         = 5;
    localparam int          ST_LOS        = 6;
    localparam int          ST_SAV_LSB    = 8;
    localparam logic [6:0]  FLAGS_RST     = 7'h03;

    // serial frame: [15:14] index, [13] write, [12:1] data, [0] parity
    localparam int          FRAME_BITS    = 16;
    localparam logic [4:0]  FRAME_LEN     = 5'h10;
    localparam logic [4:0]  FRAME_SAT     = 5'h11;
    localparam int          SER_IDX_LSB   = 14;
    localparam int          SER_WR_BIT    = 13;
    localparam int          SER_DATA_LSB  = 1;
    localparam logic [1:0]  SER_IDX_CTRL  = 2'h0;
    localparam logic [1:0]  SER_IDX_SPEED = 2'h1;

    // speed compare forms
    localparam logic [2:0]  US_LOW_ZEROS  = 3'h0;
    localparam logic [6:0]  OS_LOW_ONES   = 7'h7f;

    // synchroniser reset: strobe idles high in bit 0
    localparam int          ASYNC_W       = 7;
    localparam logic [6:0]  SYNC_RST      = 7'h01;

    // supervision times
    localparam int          CLK_KHZ       = 250000;
    localparam int          RST_HOLD_MS   = 10;
    localparam int          WD_HOLD_MS    = 100;
    localparam int          RST_HOLD_CYC  = RST_HOLD_MS * CLK_KHZ;
    localparam int          WD_HOLD_CYC   = WD_HOLD_MS * CLK_KHZ;
    localparam int          CNT_W         = 25;

    typedef enum logic [1:0] {
        SAV_IDLE = 2'h0,
        SAV_BUSY = 2'h1,
        SAV_OK   = 2'h2,
        SAV_FAIL = 2'h3
    } save_state_t;

    typedef enum logic [4:0] {
        LR_RUN  = 5'b00001,
        LR_LOW  = 5'b00010,
        LR_HOLD = 5'b00100,
        LR_WDH  = 5'b01000,
        LR_WAIT = 5'b10000
    } lr_state_t;

endpackage

`default_nettype wire

// [fault_monitor.sv]
/*
 * Chip-level fault supervisor: charge-pump and logic-regulator undervoltage,
 * microcontroller reset and watchdog hold-off, programming-supply check,
 * serial frame checks, load failure and loss of synchronisation.
 * Assumes comparator levels, watchdog and serial pins are asynchronous;
 * the save engine and commutation controller share ref_clk_in.
 */
// Notes on behaviour
// - charge-pump undervoltage sets its flag and drops all gate drives
// - gates return when the charge pump recovers; its flag stays latched
// - logic-regulator undervoltage sets flag, pulls MCU reset low, drops gates
// - after recovery hold MCU reset low 10 ms, then release and clear watchdog
// - watchdog held in reset and its input ignored for 100 ms
// - restart on first watchdog transition when run, restart and demand allow
// - without restart, gates wait for watchdog transition plus a clear event
// - programming supply drop aborts save, sets fault flags, reports failure
// - programming undervoltage flag only settable during a save
// - length error when frame has other than 16 clock edges
// - parity error when the 16-bit frame has an even count of ones
// - bad frames write nothing, skip status clear, set fault and serial error
// - serial error holds until a status read or good frame with read-clear, or reset
// - load failure sets serial error and power-on, defaults, forces run off
// - underspeed threshold is eight times code times resolution
// - overspeed threshold is 127 plus 128 times code, times resolution
// - overspeed compare is code over seven ones, eleven bits
// - underspeed code aligns with reference speed bits 6 to 3
// - commanded speed out of window sets sync-lost flag and coasts
// - missing zero crossing lowers commutation rate at each expected point
// - sync loss with run, restart and demand retries the start sequence
// - sync loss without restart coasts until a clear event
// - fault flags latch until reset or a read or good frame with read-clear
// - reset leaves defaults with general fault and power-on flags set
`timescale 1ns/1ps
`default_nettype none

module fault_monitor
    import fault_mon_pkg::*;
#(
    parameter int RST_HOLD_CYCLES = RST_HOLD_CYC,
    parameter int WD_HOLD_CYCLES  = WD_HOLD_CYC,
    parameter int RES_BASE_HZ     = 1
) (
    // clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [DATA_W-1:0]   reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [DATA_W-1:0]   reg_rdata_out,
    // supply comparators, high while below threshold
    input  wire logic                cp_uv_in,
    input  wire logic                logic_uv_in,
    input  wire logic                prog_uv_in,
    // microcontroller supervision
    input  wire logic                watchdog_input_in,
    output logic                     mcu_reset_out_n,
    output logic                     watchdog_clear_out,
    // serial port
    input  wire logic                sck_in,
    input  wire logic                sdi_in,
    input  wire logic                serial_strobe_n_in,
    // non-volatile store
    input  wire logic                nvm_write_active_in,
    input  wire logic                nvm_write_done_in,
    input  wire logic                nvm_load_fail_in,
    output logic                     nvm_abort_out,
    // commutation controller
    input  wire logic                motor_active_in,
    input  wire logic [SPD_W-1:0]    commanded_speed_in,
    input  wire logic                demand_zero_in,
    input  wire logic                demand_ok_in,
    input  wire logic                comm_point_in,
    input  wire logic                zero_cross_seen_in,
    output logic                     slow_commutation_out,
    output logic                     start_retry_out,
    output logic                     gate_enable_out
);

    if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES >= (1 << CNT_W) ||
        WD_HOLD_CYCLES < 1 || WD_HOLD_CYCLES >= (1 << CNT_W) ||
        RES_BASE_HZ < 1 || RES_BASE_HZ > 255) begin : g_bad_param
        $error("fault_monitor: hold counts or resolution out of range");
    end

    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WD_LAST  = CNT_W'(WD_HOLD_CYCLES - 1);

    // pin synchronisers and edge history
    logic [ASYNC_W-1:0] sync1_r;
    logic [ASYNC_W-1:0] sync2_r;
    logic               sck_d_r;
    logic               stb_d_r;
    logic               wd_d_r;
    logic               dmd_zero_d_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {cp_uv_in, logic_uv_in, prog_uv_in, watchdog_input_in,
                        sck_in, sdi_in, serial_strobe_n_in};
            sync2_r <= sync1_r;
        end
    end

    wire cp_uv_s   = sync2_r[6];
    wire lr_uv_s   = sync2_r[5];
    wire pp_uv_s   = sync2_r[4];
    wire wd_s      = sync2_r[3];
    wire sck_s     = sync2_r[2];
    wire sdi_s     = sync2_r[1];
    wire stb_s     = sync2_r[0];

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_d_r      <= 1'b0;
            stb_d_r      <= 1'b1;
            wd_d_r       <= 1'b0;
            dmd_zero_d_r <= 1'b0;
        end else begin
            sck_d_r      <= sck_s;
            stb_d_r      <= stb_s;
            wd_d_r       <= wd_s;
            dmd_zero_d_r <= demand_zero_in;
        end
    end

    wire sck_rise  = sck_s & ~sck_d_r;
    wire stb_fall  = ~stb_s & stb_d_r;
    wire stb_rise  = stb_s & ~stb_d_r;
    wire wd_edge   = wd_s ^ wd_d_r;
    wire dmd_reset = demand_zero_in & ~dmd_zero_d_r;

    // serial frame capture
    logic [4:0]            bit_cnt_r;
    logic [FRAME_BITS-1:0] shift_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_r <= 5'h00;
            shift_r   <= '0;
        end else if (stb_fall) begin
            bit_cnt_r <= 5'h00;
        end else if (sck_rise && !stb_s) begin
            bit_cnt_r <= (bit_cnt_r == FRAME_SAT) ? FRAME_SAT : bit_cnt_r + 5'h01;
            shift_r   <= {shift_r[FRAME_BITS-2:0], sdi_s};
        end
    end

    wire len_err  = stb_rise & (bit_cnt_r != FRAME_LEN);
    wire par_err  = stb_rise & ~(^shift_r);
    wire ser_err  = len_err | par_err;
    wire ser_ok   = stb_rise & ~ser_err;
    // only a clean frame may write
    wire ser_wr   = ser_ok & shift_r[SER_WR_BIT];
    wire [1:0]  ser_idx  = shift_r[SER_IDX_LSB +: 2];
    wire [11:0] ser_data = shift_r[SER_DATA_LSB +: 12];

    // configuration registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [SPD_W-1:0]  spd_r;
    logic              sys_err_r;

    wire sw_ctrl_wr  = reg_wr_in & (reg_addr_in == CTRL_OFS);
    wire sw_spd_wr   = reg_wr_in & (reg_addr_in == SPEED_OFS);
    wire ser_ctrl_wr = ser_wr & (ser_idx == SER_IDX_CTRL);
    wire ser_spd_wr  = ser_wr & (ser_idx == SER_IDX_SPEED);

    wire [CTRL_W-1:0] ctrl_nxt = sw_ctrl_wr  ? reg_wdata_in[CTRL_W-1:0] :
                                 ser_ctrl_wr ? ser_data[CTRL_W-1:0] : ctrl_r;
    wire [SPD_W-1:0]  spd_nxt  = sw_spd_wr   ? reg_wdata_in[SPD_W-1:0] :
                                 ser_spd_wr  ? ser_data[SPD_W-1:0] : spd_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= CTRL_RST;
            spd_r  <= SPD_RST;
        end else if (nvm_load_fail_in) begin
            ctrl_r <= CTRL_RST;
            spd_r  <= SPD_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            spd_r  <= spd_nxt;
        end
    end

    // run held off until a good frame, set wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_err_r <= 1'b0;
        end else begin
            sys_err_r <= nvm_load_fail_in | (sys_err_r & ~ser_ok);
        end
    end

    wire run_bit  = ctrl_r[CTRL_RUN_BIT];
    wire run_eff  = run_bit & ~sys_err_r;
    wire rsc_bit  = ctrl_r[CTRL_RSC_BIT];
    wire dsr_zero = ~ctrl_r[CTRL_DSR_BIT];
    wire run_fall = run_bit & ~ctrl_nxt[CTRL_RUN_BIT];

    // status read clear, good frame clear; bad frames skip it
    wire st_read     = reg_rd_in & (reg_addr_in == STATUS_OFS);
    wire flag_clr    = (st_read | ser_ok) & dsr_zero;
    wire clr_evt     = dmd_reset | run_fall | flag_clr;
    wire restart_ok  = run_eff & rsc_bit & demand_ok_in;

    // speed window
    wire [3:0] us_code = spd_r[US_LSB +: 4];
    wire [3:0] os_code = spd_r[OS_LSB +: 4];
    wire [2:0] res_sel = spd_r[RES_LSB +: 3];
    // underspeed code on reference bits 6:3
    wire [SPD_W-1:0] us_cmp = {4'h0, us_code, US_LOW_ZEROS};
    wire [SPD_W-1:0] os_cmp = {os_code, OS_LOW_ONES};
    wire [15:0]      res_hz = 16'(RES_BASE_HZ) << res_sel;
    wire [DATA_W-1:0] us_hz = DATA_W'(us_cmp) * DATA_W'(res_hz);
    wire [DATA_W-1:0] os_hz = DATA_W'(os_cmp) * DATA_W'(res_hz);

    wire los_evt = motor_active_in & gate_enable_out &
                   ((commanded_speed_in < us_cmp) | (commanded_speed_in > os_cmp));

    // save supervision
    save_state_t sav_r;
    // comparator only looked at during a save
    wire pp_uv_hit = pp_uv_s & nvm_write_active_in;
    assign nvm_abort_out = pp_uv_hit;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sav_r <= SAV_IDLE;
        end else if (pp_uv_hit) begin
            sav_r <= SAV_FAIL;
        end else if (nvm_write_done_in) begin
            sav_r <= SAV_OK;
        end else if (nvm_write_active_in) begin
            sav_r <= SAV_BUSY;
        end
    end

    // status flags, set wins over clear
    logic [FLAG_W-1:0] flags_r;
    logic [FLAG_W-1:0] flag_set;

    always_comb begin
        flag_set            = '0;
        flag_set[ST_CPUV]   = cp_uv_s;
        flag_set[ST_LRUV]   = lr_uv_s;
        flag_set[ST_PPUV]   = pp_uv_hit;
        flag_set[ST_SE]     = ser_err | nvm_load_fail_in;
        flag_set[ST_POR]    = nvm_load_fail_in;
        flag_set[ST_LOS]    = los_evt;
        flag_set[ST_FF]     = ser_err | pp_uv_hit | cp_uv_s | lr_uv_s | los_evt;
    end

    wire [FLAG_W-1:0] flags_nxt = (flags_r & ~{FLAG_W{flag_clr}}) | flag_set;

    // reset leaves general fault and power-on set
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // logic-regulator sequencer
    lr_state_t        lr_state_r;
    lr_state_t        lr_state_nxt;
    logic [CNT_W-1:0] hold_cnt_r;
    logic             wd_seen_r;
    logic             clr_seen_r;
    logic             lr_retry;

    wire wd_ok  = wd_seen_r | wd_edge;
    wire clr_ok = clr_seen_r | clr_evt;

    always_comb begin
        lr_state_nxt = lr_state_r;
        lr_retry     = 1'b0;
        unique case (lr_state_r)
            LR_RUN: begin
                if (lr_uv_s) lr_state_nxt = LR_LOW;
            end
            LR_LOW: begin
                if (!lr_uv_s) lr_state_nxt = LR_HOLD;
            end
            LR_HOLD: begin
                if (lr_uv_s) lr_state_nxt = LR_LOW;
                else if (hold_cnt_r == RST_LAST) lr_state_nxt = LR_WDH;
            end
            LR_WDH: begin
                if (lr_uv_s) lr_state_nxt = LR_LOW;
                else if (hold_cnt_r == WD_LAST) lr_state_nxt = LR_WAIT;
            end
            LR_WAIT: begin
                if (lr_uv_s) begin
                    lr_state_nxt = LR_LOW;
                end else if (wd_ok && (restart_ok || clr_ok)) begin
                    lr_state_nxt = LR_RUN;
                    lr_retry     = restart_ok;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lr_state_r <= LR_LOW;
            hold_cnt_r <= '0;
            wd_seen_r  <= 1'b0;
            clr_seen_r <= 1'b0;
        end else begin
            lr_state_r <= lr_state_nxt;
            hold_cnt_r <= (lr_state_nxt != lr_state_r) ? '0 : hold_cnt_r + 1'b1;
            // watchdog edges during hold-off are not counted
            wd_seen_r  <= (lr_state_r == LR_WAIT) & wd_ok;
            // clear events remembered from the undervoltage onward
            clr_seen_r <= (lr_state_r != LR_RUN) & (lr_state_nxt != LR_RUN) & clr_ok;
        end
    end

    // sync-loss latch
    logic los_hold_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            los_hold_r <= 1'b0;
        end else begin
            los_hold_r <= (los_evt & ~restart_ok) | (los_hold_r & ~clr_evt);
        end
    end

    // outputs from flops
    logic       mcu_rst_n_r;
    logic       wd_clr_r;
    logic       gate_en_r;
    logic       retry_r;
    logic       slow_r;
    logic [DATA_W-1:0] rdata_r;

    wire gate_nxt = ~cp_uv_s & ~lr_uv_s & (lr_state_nxt == LR_RUN) &
                    ~los_evt & ~(los_hold_r & ~clr_evt) & run_eff;

    wire [DATA_W-1:0] status_word = DATA_W'({sav_r, 1'b0, flags_r});
    wire [DATA_W-1:0] rd_mux =
        (reg_addr_in == CTRL_OFS)   ? DATA_W'(ctrl_r) :
        (reg_addr_in == SPEED_OFS)  ? DATA_W'(spd_r)  :
        (reg_addr_in == STATUS_OFS) ? status_word     :
        (reg_addr_in == US_THR_OFS) ? us_hz           :
        (reg_addr_in == OS_THR_OFS) ? os_hz           : '0;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mcu_rst_n_r <= 1'b0;
            wd_clr_r    <= 1'b1;
            gate_en_r   <= 1'b0;
            retry_r     <= 1'b0;
            slow_r      <= 1'b0;
            rdata_r     <= '0;
        end else begin
            // reset low through undervoltage and 10 ms hold
            mcu_rst_n_r <= ~((lr_state_nxt == LR_LOW) | (lr_state_nxt == LR_HOLD));
            // watchdog held in reset until hold-off ends
            wd_clr_r    <= (lr_state_nxt != LR_RUN) & (lr_state_nxt != LR_WAIT);
            gate_en_r   <= gate_nxt;
            retry_r     <= lr_retry | (los_evt & restart_ok);
            // lower rate at a point with no zero crossing
            slow_r      <= comm_point_in & ~zero_cross_seen_in & motor_active_in;
            rdata_r     <= reg_rd_in ? rd_mux : '0;
        end
    end

    assign mcu_reset_out_n      = mcu_rst_n_r;
    assign watchdog_clear_out   = wd_clr_r;
    assign gate_enable_out      = gate_en_r;
    assign start_retry_out      = retry_r;
    assign slow_commutation_out = slow_r;
    assign reg_rdata_out        = rdata_r;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_cp_uv;
        cp_uv_s |=> !gate_enable_out && flags_r[ST_CPUV] && flags_r[ST_FF];
    endproperty
    a_cp_uv: assert property (p_cp_uv) else $error("charge-pump uv not acted on");

    property p_lr_uv;
        lr_uv_s |=> !mcu_reset_out_n && !gate_enable_out && flags_r[ST_LRUV];
    endproperty
    a_lr_uv: assert property (p_lr_uv) else $error("logic uv not acted on");

    property p_rst_release;
        (lr_state_r == LR_HOLD) && (hold_cnt_r == RST_LAST) && !lr_uv_s
        |=> mcu_reset_out_n && watchdog_clear_out && (lr_state_r == LR_WDH);
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("mcu reset release wrong");

    property p_wd_ignore;
        (lr_state_r == LR_WDH) && (hold_cnt_r != WD_LAST) && wd_edge
        |=> (lr_state_r != LR_RUN) && !wd_seen_r;
    endproperty
    a_wd_ignore: assert property (p_wd_ignore) else $error("watchdog not ignored");

    property p_len_err;
        len_err |=> flags_r[ST_SE] && flags_r[ST_FF] && $stable(ctrl_r) && $stable(spd_r);
    endproperty
    a_len_err: assert property (p_len_err) else $error("length error not handled");

    property p_par_err;
        stb_rise && (bit_cnt_r == FRAME_LEN) && !(^shift_r) |=> flags_r[ST_SE];
    endproperty
    a_par_err: assert property (p_par_err) else $error("parity error missed");

    property p_pp_idle;
        !nvm_write_active_in && !flags_r[ST_PPUV] |=> !flags_r[ST_PPUV];
    endproperty
    a_pp_idle: assert property (p_pp_idle) else $error("prog uv set outside save");

    property p_pp_abort;
        pp_uv_s && nvm_write_active_in |-> nvm_abort_out ##1 (sav_r == SAV_FAIL);
    endproperty
    a_pp_abort: assert property (p_pp_abort) else $error("save not aborted");

    property p_load_fail;
        nvm_load_fail_in |=> flags_r[ST_POR] && flags_r[ST_SE] && !run_eff;
    endproperty
    a_load_fail: assert property (p_load_fail) else $error("load failure not flagged");

    property p_los;
        los_evt |=> flags_r[ST_LOS] && !gate_enable_out;
    endproperty
    a_los: assert property (p_los) else $error("sync loss not acted on");

    property p_flag_hold;
        flags_r[ST_LOS] && !flag_clr |=> flags_r[ST_LOS];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("latched flag dropped");

    c_good_frame: cover property (ser_wr);
    c_retry: cover property (lr_retry ##1 start_retry_out);
    c_los_latch: cover property (los_evt && !restart_ok ##1 los_hold_r);
    c_abort: cover property (pp_uv_hit);

endmodule

`default_nettype wire

// [mcu_model.sv]
/*
 * Microcontroller model on the serial port and watchdog pin.
 * Assumes the link clock is free of the system clock; it runs only in frames.
 */
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
    // serial port and watchdog
    output var logic sck_out,
    output var logic sdi_out,
    output var logic strobe_n_out,
    output var logic wd_out
);
    initial begin
        {sck_out, sdi_out, strobe_n_out, wd_out} = 4'h2;
    end
    // send the low n bits of f, most significant first, 32 ns clock
    task automatic send(input logic [16:0] f, input int n);
        strobe_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = f[i];
            #16 sck_out = 1'b1;
            #16 sck_out = 1'b0;
        end
        #16 strobe_n_out = 1'b1;
        // released data line shows the inverse of its last bit
        sdi_out = ~sdi_out;
        // strobe stays high long enough to be seen between frames
        #64;
    endtask
    // one watchdog transition, clear of the clock edge
    task automatic kick();
        #1 wd_out = ~wd_out;
    endtask
endmodule
`default_nettype wire

// [motor_driver_fault_monitor_tb.sv]
/*
 * Self-checking bench for the fault supervisor.
 * Assumes short hold counts of 20 and 40 cycles and a 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_driver_fault_monitor_tb;
    import fault_mon_pkg::*;
    logic        clk, rst_n, wr, rd, cp, lu, pu, act;
    logic [4:0]  addr;
    logic [31:0] wd, v;
    logic [6:0]  cm;
    logic [10:0] spd;
    wire logic   sck, sdi, strb_n, wdg, mrst_n, abrt, gate, slow, retry, wdclr;
    wire logic [31:0] rdata;
    int num_errors = 0;
    int num_checks = 0;
    fault_monitor #(.RST_HOLD_CYCLES(20), .WD_HOLD_CYCLES(40)) i_dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .cp_uv_in(cp),
        .logic_uv_in(lu), .prog_uv_in(pu), .watchdog_input_in(wdg),
        .mcu_reset_out_n(mrst_n), .watchdog_clear_out(wdclr), .sck_in(sck), .sdi_in(sdi),
        .serial_strobe_n_in(strb_n), .nvm_write_active_in(act),
        .nvm_write_done_in(cm[0]), .nvm_load_fail_in(cm[1]), .nvm_abort_out(abrt),
        .motor_active_in(cm[2]), .commanded_speed_in(spd), .demand_zero_in(cm[3]),
        .demand_ok_in(cm[4]), .comm_point_in(cm[5]), .zero_cross_seen_in(cm[6]),
        .slow_commutation_out(slow), .start_retry_out(retry), .gate_enable_out(gate));
    mcu_model i_mcu (.sck_out(sck), .sdi_out(sdi), .strobe_n_out(strb_n), .wd_out(wdg));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdr(input logic [4:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wrr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic t_regs();
        rdr(STATUS_OFS);
        chk("status", v, 32'h3);
        rdr(STATUS_OFS);
        chk("cleared", v, 32'h0);
        rdr(SPEED_OFS);
        chk("speed", v, {21'h0, SPD_RST});
        wrr(US_THR_OFS, 32'hff);
        rdr(US_THR_OFS);
        chk("us ro", v, 32'd8);
        wrr(CTRL_OFS, 32'h3);
        rdr(CTRL_OFS);
        chk("ctrl", v, 32'h3);
        rdr(5'h1c);
        chk("unmapped", v, 32'h0);
        wrr(CTRL_OFS, 32'h0);
    endtask
    task automatic t_uv();
        cp <= 1'b1;
        repeat (6) @(posedge clk);
        chk("gate", {31'h0, gate}, 32'h0);
        cp <= 1'b0;
        lu <= 1'b1;
        repeat (6) @(posedge clk);
        chk("mcu rst", {31'h0, mrst_n}, 32'h0);
        lu <= 1'b0;
        repeat (10) @(posedge clk);
        chk("mcu hold", {31'h0, mrst_n}, 32'h0);
        for (int i = 0; i < 40 && mrst_n !== 1'b1; i++) @(posedge clk);
        chk("mcu rel", {31'h0, mrst_n}, 32'h1);
        chk("wd hold", {31'h0, wdclr}, 32'h1);
        rdr(STATUS_OFS);
        chk("uv flags", v & 32'hc, 32'hc);
    endtask
    task automatic t_serial();
        i_mcu.send(17'h6265, 16);
        repeat (8) @(posedge clk);
        rdr(SPEED_OFS);
        chk("speed", v, 32'h132);
        rdr(US_THR_OFS);
        chk("us thr", v, 32'({4'h2, 3'h0}) * 2);
        rdr(OS_THR_OFS);
        chk("os thr", v, (32'd127 + 32'd128 * 3) * 2);
        i_mcu.send(17'h6464, 16);
        i_mcu.send(17'h6265, 15);
        repeat (8) @(posedge clk);
        rdr(STATUS_OFS);
        chk("se", v & 32'h21, 32'h21);
        rdr(SPEED_OFS);
        chk("no write", v, 32'h132);
    endtask
    task automatic t_save();
        act <= 1'b1;
        pu <= 1'b1;
        repeat (5) @(posedge clk);
        chk("abort", {31'h0, abrt}, 32'h1);
        act <= 1'b0;
        rdr(STATUS_OFS);
        chk("save fail", v & 32'h311, 32'h311);
        repeat (5) @(posedge clk);
        rdr(STATUS_OFS);
        chk("pp idle", v & 32'h10, 32'h0);
        pu <= 1'b0;
    endtask
    task automatic t_gate();
        int n = 0;
        wrr(CTRL_OFS, 32'h3);
        spd <= 11'h100;
        cm <= 7'h14;
        i_mcu.kick();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            n += retry;
        end
        chk("retry", n, 1);
        chk("gate on", {31'h0, gate}, 32'h1);
        cp <= 1'b1;
        repeat (4) @(posedge clk);
        chk("cp gate", {31'h0, gate}, 32'h0);
        cp <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cp back", {31'h0, gate}, 32'h1);
        spd <= 11'h0;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            n += retry;
        end
        chk("retries", 32'(n > 1), 32'h1);
        rdr(STATUS_OFS);
        chk("los", v & 32'h40, 32'h40);
        spd <= 11'h100;
        wrr(CTRL_OFS, 32'h1);
        spd <= 11'h0;
        repeat (4) @(posedge clk);
        spd <= 11'h100;
        repeat (4) @(posedge clk);
        chk("coast", {31'h0, gate}, 32'h0);
        cm <= 7'h1c;
        repeat (4) @(posedge clk);
        chk("demand reset", {31'h0, gate}, 32'h1);
    endtask
    task automatic t_load();
        cm[1] <= 1'b1;
        @(posedge clk);
        cm[1] <= 1'b0;
        rdr(STATUS_OFS);
        chk("load fail", v & 32'h22, 32'h22);
        rdr(CTRL_OFS);
        chk("defaults", v, 32'h0);
        chk("run off", {31'h0, gate}, 32'h0);
        cm[5] <= 1'b1;
        @(posedge clk);
        cm[5] <= 1'b0;
        @(posedge clk);
        chk("slow", {31'h0, slow}, 32'h1);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rst_n, wr, rd, cp, lu, pu, act, addr, wd, cm, spd} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_uv();
        t_serial();
        t_save();
        t_gate();
        t_load();
        summarize();
    end
endmodule
`default_nettype wire
